// [hdl/csfb_defines.svh]
// register offsets, field positions and reset values of the system flag bank
`ifndef CSFB_DEFINES_SVH
`define CSFB_DEFINES_SVH

// byte addresses of the word registers
`define CSFB_ADDR_CTRL      8'h00
`define CSFB_ADDR_STATUS    8'h04
`define CSFB_ADDR_EVENT     8'h08
`define CSFB_ADDR_MASK      8'h0C
`define CSFB_ADDR_LOOPBACK  8'h10

// control register fields
`define CSFB_CTRL_PROT      0
`define CSFB_CTRL_CFG_SAVE  1
`define CSFB_CTRL_MSG_RST   2
`define CSFB_CTRL_MEAS      3
`define CSFB_CTRL_FB_SAVE   4
`define CSFB_CTRL_FB_REST   5

// status register fields, same order as the pin group
`define CSFB_ST_BATT        0
`define CSFB_ST_TERM_SLAVE  1
`define CSFB_ST_DIAG_CFG    2
`define CSFB_ST_DIAG_FULL   3
`define CSFB_ST_REMOTE_OK   4
`define CSFB_ST_RACK_OK     5
`define CSFB_PIN_W          6

// event and mask register fields
`define CSFB_EV_REFRESH     0
`define CSFB_EV_COMMON      1
`define CSFB_EV_W           2

// reset values: fault flags rest at one, all else zero
`define CSFB_PIN_RST        6'h30
`define CSFB_EV_RST         2'h0
`define CSFB_MASK_RST       2'h0

// loop-back time is meaningful below this limit, counted in tenths of ms
`define CSFB_LB_LIMIT_S     10
`define CSFB_LB_TENTHS_PER_S 10000
`define CSFB_LB_LIMIT       (`CSFB_LB_LIMIT_S * `CSFB_LB_TENTHS_PER_S)
`define CSFB_LB_W           20
`define CSFB_LB_VALID_BIT   31

`endif

// [hdl/csfb_pkg.sv]
// types shared by the system flag bank
package csfb_pkg;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} csfb_apb_req_t;

	// apb answer to the master
	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} csfb_apb_rsp_t;

	// status levels arriving from pins, bit 0 last
	typedef struct packed {
		logic rack_ok;
		logic remote_ok;
		logic diag_full;
		logic diag_cfg;
		logic term_slave;
		logic batt_fail;
	} csfb_pins_t;

	// command outputs toward the surrounding logic
	typedef struct packed {
		logic protected_mode;
		logic measure_mode;
		logic cfg_save;
		logic msg_counter_reset;
		logic fb_adjust_save;
		logic fb_adjust_restore;
	} csfb_cmd_t;

	// complete state of the bank
	typedef struct packed {
		logic [5:0]  pin_s1;
		logic [5:0]  pin_s2;
		logic        prot_mode;
		logic        cfg_save;
		logic        meas_mode;
		logic [1:0]  ev;
		logic [1:0]  mask;
		logic        msg_rst_p;
		logic        fb_save_p;
		logic        fb_rest_p;
		logic        cfg_save_p;
		logic        irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} csfb_state_t;

endpackage : csfb_pkg

// [hdl/csfb_flag_bank.sv]
// system flag bank: apb slave, flag registers, command pulses, interrupt
// Behaviour
// - battery flag: 0 working, 1 missing
// - refresh flag set per scan, user clears
// - protected mode only after config save set
// - config save write 1 saves configuration; the save pulse fires only on a zero to one write
// - message counter reset command pulses reset
// - measure mode exposes loop-back time below 10 s
// - save command stores block adjustments
// - restore command reloads block adjustments
// - terminal protocol: 0 master, 1 slave
// - diagnostic buffer configured flag
// - diagnostic buffer full flag
// - remote bus fault flag low on fault
// - rack bus fault flag low on fault
`timescale 1ns/1ps
`include "csfb_defines.svh"

module csfb_flag_bank
	import csfb_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	input  wire csfb_apb_req_t          apb_req,
	output csfb_apb_rsp_t               apb_rsp,
	input  wire csfb_pins_t             pins,
	input  wire logic                   fieldbus_scan_done,
	input  wire logic                   common_words_rx,
	input  wire logic [`CSFB_LB_W-1:0]  loopback_time,
	output csfb_cmd_t                   cmd,
	output logic                        irq
);

	csfb_state_t st_ff;       // registered state
	csfb_state_t nxt_st;      // next state

	logic        acc_prep;    // access phase, answer not yet given
	logic        acc_done;    // access phase completing this edge
	logic        wr_done;     // write takes effect this edge
	logic [31:0] wdata;       // write data shortcut
	logic [1:0]  ev_set;      // hardware event sets this cycle
	logic        lb_valid;    // loop-back time is meaningful
	logic [31:0] lb_word;     // loop-back register read value
	logic [31:0] rd_word;     // read mux result
	logic        rd_err;      // unmapped address

	// apb phases: one wait cycle so read data comes from a flip-flop
	assign acc_prep = apb_req.psel & apb_req.penable & ~st_ff.pready;
	assign acc_done = apb_req.psel & apb_req.penable & st_ff.pready;
	assign wr_done  = acc_done & apb_req.pwrite & ~st_ff.pslverr;
	assign wdata    = apb_req.pwdata;

	// events from same-clock logic need no synchroniser
	assign ev_set[`CSFB_EV_REFRESH] = fieldbus_scan_done;
	assign ev_set[`CSFB_EV_COMMON]  = common_words_rx;

	// loop-back value beyond the limit is flagged, not clipped
	assign lb_valid = st_ff.meas_mode &
		(loopback_time < `CSFB_LB_W'(`CSFB_LB_LIMIT));

	// read value of the loop-back register, zero outside measure mode
	always_comb
	begin
		lb_word = 32'h0000_0000;
		if (st_ff.meas_mode)
		begin
			lb_word[`CSFB_LB_W-1:0]     = loopback_time;
			lb_word[`CSFB_LB_VALID_BIT] = lb_valid;
		end
	end

	// read mux over the register map
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_err  = 1'b0;
		case (apb_req.paddr)
			`CSFB_ADDR_CTRL:
			begin
				// command bits rest at zero and read as zero
				rd_word[`CSFB_CTRL_PROT]     = st_ff.prot_mode;
				rd_word[`CSFB_CTRL_CFG_SAVE] = st_ff.cfg_save;
				rd_word[`CSFB_CTRL_MEAS]     = st_ff.meas_mode;
			end
			`CSFB_ADDR_STATUS:
			begin
				rd_word[`CSFB_PIN_W-1:0] = st_ff.pin_s2;
			end
			`CSFB_ADDR_EVENT:
				rd_word[`CSFB_EV_W-1:0] = st_ff.ev;
			`CSFB_ADDR_MASK:
				rd_word[`CSFB_EV_W-1:0] = st_ff.mask;
			`CSFB_ADDR_LOOPBACK:
				rd_word = lb_word;
			default:
				// unmapped: zero data and an error answer
				rd_err = 1'b1;
		endcase
	end

	// next state of the whole bank
	always_comb
	begin
		nxt_st = st_ff;

		// status pin levels, the two fault flags low on fault
		// only pin_s2 is read, so a metastable first stage never
		// reaches the register map or the assertions' status view
		nxt_st.pin_s1 = pins;
		nxt_st.pin_s2 = st_ff.pin_s1;

		// command pulses last one cycle only
		nxt_st.msg_rst_p  = 1'b0;
		nxt_st.fb_save_p  = 1'b0;
		nxt_st.fb_rest_p  = 1'b0;
		nxt_st.cfg_save_p = 1'b0;

		// apb answer timing
		nxt_st.pready = acc_prep;
		if (acc_prep)
		begin
			nxt_st.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_word;
			nxt_st.pslverr = rd_err;
		end
		else if (acc_done)
		begin
			nxt_st.prdata  = 32'h0000_0000;
			nxt_st.pslverr = 1'b0;
		end

		// register writes
		if (wr_done)
		begin
			case (apb_req.paddr)
				`CSFB_ADDR_CTRL:
				begin
					// save pulse on a zero to one write
					nxt_st.cfg_save   = wdata[`CSFB_CTRL_CFG_SAVE];
					nxt_st.cfg_save_p = wdata[`CSFB_CTRL_CFG_SAVE] &
						~st_ff.cfg_save;
					// protected mode gated by prior save
					if (!wdata[`CSFB_CTRL_PROT])
						nxt_st.prot_mode = 1'b0;
					else if (st_ff.cfg_save)
						nxt_st.prot_mode = 1'b1;
					// a refused request simply leaves the bit as it was
					nxt_st.meas_mode = wdata[`CSFB_CTRL_MEAS];
					nxt_st.msg_rst_p = wdata[`CSFB_CTRL_MSG_RST];
					nxt_st.fb_save_p = wdata[`CSFB_CTRL_FB_SAVE];
					nxt_st.fb_rest_p = wdata[`CSFB_CTRL_FB_REST];
				end
				`CSFB_ADDR_EVENT:
					nxt_st.ev = st_ff.ev & ~wdata[`CSFB_EV_W-1:0];
				`CSFB_ADDR_MASK:
					nxt_st.mask = wdata[`CSFB_EV_W-1:0];
				default:
					nxt_st.ev = st_ff.ev;
			endcase
		end

		// event set wins over a clear
		nxt_st.ev = nxt_st.ev | ev_set;

		// level interrupt from unmasked sticky events
		nxt_st.irq = |(nxt_st.ev & nxt_st.mask);
	end

	// state register
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_ff.pin_s1     <= `CSFB_PIN_RST;
			st_ff.pin_s2     <= `CSFB_PIN_RST;
			st_ff.prot_mode  <= 1'b0;
			st_ff.cfg_save   <= 1'b0;
			st_ff.meas_mode  <= 1'b0;
			st_ff.ev         <= `CSFB_EV_RST;
			st_ff.mask       <= `CSFB_MASK_RST;
			st_ff.msg_rst_p  <= 1'b0;
			st_ff.fb_save_p  <= 1'b0;
			st_ff.fb_rest_p  <= 1'b0;
			st_ff.cfg_save_p <= 1'b0;
			st_ff.irq        <= 1'b0;
			st_ff.pready     <= 1'b0;
			st_ff.pslverr    <= 1'b0;
			st_ff.prdata     <= 32'h0000_0000;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flops; one assignment per output struct
	// so each port variable has a single continuous driver
	assign apb_rsp = '{
		pready:  st_ff.pready,
		prdata:  st_ff.prdata,
		pslverr: st_ff.pslverr
	};
	assign cmd = '{
		protected_mode:    st_ff.prot_mode,
		measure_mode:      st_ff.meas_mode,
		cfg_save:          st_ff.cfg_save_p,
		msg_counter_reset: st_ff.msg_rst_p,
		fb_adjust_save:    st_ff.fb_save_p,
		fb_adjust_restore: st_ff.fb_rest_p
	};
	assign irq     = st_ff.irq;

	// assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	logic ctrl_wr;    // control register write completes
	assign ctrl_wr = wr_done & (apb_req.paddr == `CSFB_ADDR_CTRL);

	// a pin held steady three cycles
	sequence pin_steady(logic p);
		$stable(p)[*3];
	endsequence

	// pulse of exactly one cycle
	sequence one_pulse(logic p);
		p ##1 !p;
	endsequence

	// status bit follows a pin after two flops
	property follows_pin(logic p, logic s);
		pin_steady(p) |-> (s == p);
	endproperty

	a_batt_status_follow: assert property (
		follows_pin(pins.batt_fail, st_ff.pin_s2[`CSFB_ST_BATT]))
		else $error("battery flag does not track its pin");

	a_refresh_sets_flag: assert property (
		fieldbus_scan_done |=> st_ff.ev[`CSFB_EV_REFRESH])
		else $error("scan end did not set the refresh flag");

	a_event_clear_w1c: assert property (
		(wr_done && apb_req.paddr == `CSFB_ADDR_EVENT &&
		 wdata[`CSFB_EV_COMMON] && !common_words_rx)
		|=> !st_ff.ev[`CSFB_EV_COMMON])
		else $error("write one did not clear the event flag");

	a_prot_needs_save: assert property (
		$rose(st_ff.prot_mode) |-> $past(st_ff.cfg_save))
		else $error("protected mode entered without prior save");

	a_cfg_save_pulse: assert property (
		(ctrl_wr && wdata[`CSFB_CTRL_CFG_SAVE] && !st_ff.cfg_save)
		|=> one_pulse(cmd.cfg_save))
		else $error("configuration save pulse missing");

	a_msg_reset_pulse: assert property (
		(ctrl_wr && wdata[`CSFB_CTRL_MSG_RST])
		|=> one_pulse(cmd.msg_counter_reset))
		else $error("message counter reset pulse missing");

	a_common_sets_flag: assert property (
		common_words_rx |=> st_ff.ev[`CSFB_EV_COMMON])
		else $error("common words receipt not flagged");

	a_loop_zero_idle: assert property (
		!st_ff.meas_mode |-> (lb_word == 32'h0000_0000))
		else $error("loop-back word not zero outside measure mode");

	a_fb_save_pulse: assert property (
		(ctrl_wr && wdata[`CSFB_CTRL_FB_SAVE])
		|=> one_pulse(cmd.fb_adjust_save))
		else $error("adjustment save pulse missing");

	a_fb_restore_pulse: assert property (
		(ctrl_wr && wdata[`CSFB_CTRL_FB_REST])
		|=> one_pulse(cmd.fb_adjust_restore))
		else $error("adjustment restore pulse missing");

	a_term_proto_follow: assert property (
		follows_pin(pins.term_slave, st_ff.pin_s2[`CSFB_ST_TERM_SLAVE]))
		else $error("terminal protocol flag does not track its pin");

	a_diag_cfg_follow: assert property (
		follows_pin(pins.diag_cfg, st_ff.pin_s2[`CSFB_ST_DIAG_CFG]))
		else $error("diagnostic configured flag does not track");

	a_diag_full_follow: assert property (
		follows_pin(pins.diag_full, st_ff.pin_s2[`CSFB_ST_DIAG_FULL]))
		else $error("diagnostic full flag does not track");

	a_remote_fault_lat: assert property (
		$fell(pins.remote_ok) ##1 !pins.remote_ok
		|=> !st_ff.pin_s2[`CSFB_ST_REMOTE_OK])
		else $error("remote bus fault not shown two cycles later");

	a_rack_fault_lat: assert property (
		$rose(pins.rack_ok) ##1 pins.rack_ok
		|=> st_ff.pin_s2[`CSFB_ST_RACK_OK])
		else $error("rack bus fault not released two cycles later");

	a_irq_level_mask: assert property (
		irq == (|(st_ff.ev & st_ff.mask)))
		else $error("interrupt does not follow masked events");

	a_apb_one_wait: assert property (
		acc_prep |=> apb_rsp.pready ##1 !apb_rsp.pready)
		else $error("apb answer not after exactly one wait");

	// a scan end that meets its own clearing write must survive it
	a_set_wins_clear: assert property (
		(wr_done && apb_req.paddr == `CSFB_ADDR_EVENT &&
		 wdata[`CSFB_EV_REFRESH] && fieldbus_scan_done)
		|=> st_ff.ev[`CSFB_EV_REFRESH])
		else $error("refresh clear beat a scan end in the same cycle");

	a_prot_refused: assert property (
		(ctrl_wr && wdata[`CSFB_CTRL_PROT] && !st_ff.cfg_save &&
		 !st_ff.prot_mode)
		|=> !cmd.protected_mode)
		else $error("protected mode accepted without stored save");

	// a counter reset pulse only ever follows a control write
	a_msg_reset_cause: assert property (
		cmd.msg_counter_reset |-> $past(ctrl_wr))
		else $error("message counter reset without a control write");

	a_loop_over_limit: assert property (
		(st_ff.meas_mode &&
		 loopback_time >= `CSFB_LB_W'(`CSFB_LB_LIMIT))
		|-> !lb_word[`CSFB_LB_VALID_BIT])
		else $error("loop-back time beyond the limit marked valid");

	// unmapped accesses answer with an error and zero data
	a_unmapped_error: assert property (
		(acc_prep && rd_err)
		|=> (apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000))
		else $error("unmapped access did not answer with an error");

endmodule : csfb_flag_bank

// [sim/csfb_testbench.sv]
// self-checking testbench for the system flag bank
`timescale 1ns/1ps
`include "csfb_defines.svh"

module testbench
	import csfb_pkg::*;
;
	logic                   clock;              // 50 MHz system clock
	logic                   rst_b;              // async reset, active low
	csfb_apb_req_t          apb_req;            // bus request we drive
	csfb_apb_rsp_t          apb_rsp;            // bus answer
	csfb_pins_t             pins;               // status pin levels
	logic                   fieldbus_scan_done; // end of scan pulse
	logic                   common_words_rx;    // common words pulse
	logic [`CSFB_LB_W-1:0]  loopback_time;      // loop-back time
	csfb_cmd_t              cmd;                // command outputs
	logic                   irq;                // interrupt level
	int                     num_errors;         // mismatches seen
	int                     cmp_count;          // comparisons made
	logic [31:0]            rd;                 // last read data
	logic                   er;                 // last error flag

	csfb_flag_bank dut (
		.clock              (clock),
		.rst_b              (rst_b),
		.apb_req            (apb_req),
		.apb_rsp            (apb_rsp),
		.pins               (pins),
		.fieldbus_scan_done (fieldbus_scan_done),
		.common_words_rx    (common_words_rx),
		.loopback_time      (loopback_time),
		.cmd                (cmd),
		.irq                (irq)
	);

	// free-running clock, 20 ns period
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// print counts and verdict, then stop
	task automatic close_out;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// compare one value, report at once
	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask : chk

	// one apb transfer; the answer is read just after the rising edge,
	// before the design's flops update, so it is the value sampled there
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: d};
		@(posedge clock);
		apb_req.penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (apb_rsp.pready !== 1'b1 && n < 20);
		// a slave that never answers ends the run
		if (apb_rsp.pready !== 1'b1)
		begin
			num_errors++;
			close_out();
		end
		else
		begin
			rd = apb_rsp.prdata;
			er = apb_rsp.pslverr;
			apb_req.psel    <= 1'b0;
			apb_req.penable <= 1'b0;
		end
	endtask : apb

	// read a register and compare, no error expected
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input string w);
		apb(1'b0, a, 32'h0);
		chk(w, e, rd);
		chk("pslverr", 32'h0, 32'(er));
	endtask : rd_chk

	// reset values of the status, control, event and mask registers and the interrupt
	task automatic t_reset;
		rd_chk(`CSFB_ADDR_STATUS, 32'h30, "status");
		rd_chk(`CSFB_ADDR_CTRL, 32'h0, "ctrl");
		rd_chk(`CSFB_ADDR_EVENT, 32'h0, "event");
		rd_chk(`CSFB_ADDR_MASK, 32'h0, "mask");
		chk("irq", 32'h0, 32'(irq));
	endtask : t_reset

	// flip each status pin away from rest, three edges to settle
	task automatic t_pins;
		logic [5:0] p;
		for (int i = 0; i < 6; i++)
		begin
			p = 6'h30 ^ (6'h01 << i);
			@(posedge clock);
			pins <= p;
			repeat (3) @(posedge clock);
			rd_chk(`CSFB_ADDR_STATUS, {26'h0, p}, "status");
		end
		@(posedge clock);
		pins <= 6'h30;
		repeat (3) @(posedge clock);
	endtask : t_pins

	// each event: set, masked off, masked in, cleared by writing one
	task automatic t_events;
		logic [31:0] b;
		for (int i = 0; i < 2; i++)
		begin
			b = 32'h1 << i;
			@(posedge clock);
			fieldbus_scan_done <= (i == 0);
			common_words_rx <= (i == 1);
			@(posedge clock);
			fieldbus_scan_done <= 1'b0;
			common_words_rx <= 1'b0;
			rd_chk(`CSFB_ADDR_EVENT, b, "event set");
			chk("irq masked", 32'h0, 32'(irq));
			apb(1'b1, `CSFB_ADDR_MASK, b);
			@(negedge clock);
			chk("irq", 32'h1, 32'(irq));
			apb(1'b1, `CSFB_ADDR_EVENT, b);
			rd_chk(`CSFB_ADDR_EVENT, 32'h0, "event clr");
			chk("irq clr", 32'h0, 32'(irq));
			apb(1'b1, `CSFB_ADDR_MASK, 32'h0);
		end
		// scan end held through the clearing write: the set must win
		@(posedge clock);
		fieldbus_scan_done <= 1'b1;
		apb(1'b1, `CSFB_ADDR_EVENT, 32'h1);
		fieldbus_scan_done <= 1'b0;
		rd_chk(`CSFB_ADDR_EVENT, 32'h1, "event set wins");
		apb(1'b1, `CSFB_ADDR_EVENT, 32'h1);
		rd_chk(`CSFB_ADDR_EVENT, 32'h0, "event clr again");
	endtask : t_events

	// write a control word and check the command vector just after
	task automatic wr_cmd(input logic [31:0] d, input logic [5:0] e);
		apb(1'b1, `CSFB_ADDR_CTRL, d);
		@(negedge clock);
		chk("cmd", {26'h0, e}, {26'h0, cmd});
	endtask : wr_cmd

	// self-clearing commands give a single one-cycle pulse
	task automatic t_cmds;
		logic [31:0] c [3];
		logic [5:0]  e [3];
		c = '{32'h04, 32'h10, 32'h20};
		e = '{6'h04, 6'h02, 6'h01};
		for (int i = 0; i < 3; i++)
		begin
			wr_cmd(c[i], e[i]);
			@(negedge clock);
			chk("cmd after", 32'h0, {26'h0, cmd});
			rd_chk(`CSFB_ADDR_CTRL, 32'h0, "ctrl");
		end
	endtask : t_cmds

	// protected mode refused until the save bit is stored
	task automatic t_prot;
		wr_cmd(32'h1, 6'h00);
		rd_chk(`CSFB_ADDR_CTRL, 32'h0, "ctrl refused");
		wr_cmd(32'h2, 6'h08);
		rd_chk(`CSFB_ADDR_CTRL, 32'h2, "ctrl save");
		wr_cmd(32'h3, 6'h20);
		rd_chk(`CSFB_ADDR_CTRL, 32'h3, "ctrl prot");
		wr_cmd(32'h0, 6'h00);
	endtask : t_prot

	// loop-back word only in measure mode, valid below ten seconds
	task automatic t_meas;
		@(posedge clock);
		loopback_time <= 20'h01234;
		rd_chk(`CSFB_ADDR_LOOPBACK, 32'h0, "lb off");
		wr_cmd(32'h8, 6'h10);
		rd_chk(`CSFB_ADDR_LOOPBACK, 32'h80001234, "lb");
		@(posedge clock);
		loopback_time <= 20'h1869F;
		rd_chk(`CSFB_ADDR_LOOPBACK, 32'h8001869F, "lb max");
		@(posedge clock);
		loopback_time <= 20'h186A0;
		rd_chk(`CSFB_ADDR_LOOPBACK, 32'h000186A0, "lb over");
		wr_cmd(32'h0, 6'h00);
	endtask : t_meas

	// unmapped address errors, read-only status ignores writes
	task automatic t_bad;
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped err", 32'h1, 32'(er));
		chk("unmapped data", 32'h0, rd);
		// an unmapped write errors and must not reach the control bits
		apb(1'b1, 8'h14, 32'h0000003F);
		chk("unmapped wr err", 32'h1, 32'(er));
		rd_chk(`CSFB_ADDR_CTRL, 32'h0, "ctrl untouched");
		apb(1'b1, `CSFB_ADDR_STATUS, 32'hFFFFFFFF);
		rd_chk(`CSFB_ADDR_STATUS, 32'h30, "status ro");
	endtask : t_bad

	// main sequence
	initial
	begin
		rst_b = 1'b0;
		apb_req = '0;
		pins = 6'h30;
		fieldbus_scan_done = 1'b0;
		common_words_rx = 1'b0;
		loopback_time = '0;
		num_errors = 0;
		cmp_count = 0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_pins();
		t_events();
		t_cmds();
		t_prot();
		t_meas();
		t_bad();
		close_out();
	end
endmodule : testbench
